// File: inc/uirq_consts.svh
// offsets, field positions, reset values and base addresses of the serial port irq bank
`ifndef UIRQ_CONSTS_SVH
`define UIRQ_CONSTS_SVH

// number of interrupt sources and their place in the status words
`define UIRQ_NUM_SRC        7
`define UIRQ_FIELD_LSB      4
`define UIRQ_FIELD_MSB      10

// source index within the 7-bit vector (vector bit i sits at word bit i + 4)
`define UIRQ_SRC_RX         0
`define UIRQ_SRC_TX         1
`define UIRQ_SRC_RT         2
`define UIRQ_SRC_FE         3
`define UIRQ_SRC_PE         4
`define UIRQ_SRC_BE         5
`define UIRQ_SRC_OE         6

// raw status reserved low nibble reads as ones
`define UIRQ_RAW_LOW_LSB    0
`define UIRQ_RAW_LOW_MSB    3
`define UIRQ_RAW_LOW_VAL    4'hf

// register offsets within one port instance
`define UIRQ_OFF_RAW        12'h03c
`define UIRQ_OFF_MASKED     12'h040
`define UIRQ_OFF_CLEAR      12'h044
`define UIRQ_OFF_ID4        12'hfd0
`define UIRQ_OFF_ID5        12'hfd4
`define UIRQ_OFF_ID6        12'hfd8
`define UIRQ_OFF_ID7        12'hfdc
`define UIRQ_OFF_ID0        12'hfe0
`define UIRQ_OFF_ID1        12'hfe4

// offset field of the byte address and the instance select above it
`define UIRQ_OFF_LSB        0
`define UIRQ_OFF_MSB        11
`define UIRQ_BASE_LSB       12
`define UIRQ_BASE_MSB       31

// instance bases
`define UIRQ_BASE_PORT0     32'h4000_c000
`define UIRQ_BASE_PORT1     32'h4000_d000
`define UIRQ_BASE_PORT2     32'h4000_e000

// identification bytes; byte0 value is arbitrary
`define UIRQ_ID_BYTE_W      8
`define UIRQ_ID_NUM         6
`define UIRQ_ID4_VAL        8'h00
`define UIRQ_ID5_VAL        8'h00
`define UIRQ_ID6_VAL        8'h00
`define UIRQ_ID7_VAL        8'h00
`define UIRQ_ID0_VAL        8'h5a
`define UIRQ_ID1_VAL        8'h00

// reset values
`define UIRQ_WORD_ZERO      32'h0000_0000
`define UIRQ_VEC_ZERO       7'h00

`endif

// File: inc/uirq_pkg.sv
// types shared by the serial port irq bank
package uirq_pkg;

  // one bit per interrupt source, rx at index 0 up to overrun at index 6
  typedef logic [6:0] uirq_vec_type;

  // kind of bus access seen in the current cycle
  typedef enum logic [1:0] {
    UIRQ_ACC_IDLE,
    UIRQ_ACC_READ,
    UIRQ_ACC_WRITE
  } uirq_acc_type;

endpackage

// File: rtl/uirq_id_rom.sv
// fixed identification byte lookup of the serial port irq bank
`timescale 1ns/1ps
`default_nettype none
`include "uirq_consts.svh"

module uirq_id_rom
  import uirq_pkg::*;
(
  // lookup
  input  wire logic [11:0] i_offset,
  // result
  output logic      [7:0]  o_byte,
  output logic             o_hit
);

  // offsets and values of the six id words, in table order
  localparam logic [11:0] ID_OFF [`UIRQ_ID_NUM] = '{
    `UIRQ_OFF_ID4, `UIRQ_OFF_ID5, `UIRQ_OFF_ID6,
    `UIRQ_OFF_ID7, `UIRQ_OFF_ID0, `UIRQ_OFF_ID1
  };
  localparam logic [7:0] ID_VAL [`UIRQ_ID_NUM] = '{
    `UIRQ_ID4_VAL, `UIRQ_ID5_VAL, `UIRQ_ID6_VAL,
    `UIRQ_ID7_VAL, `UIRQ_ID0_VAL, `UIRQ_ID1_VAL
  };

  logic [`UIRQ_ID_NUM-1:0] hit_vec;
  logic [7:0]              byte_vec [`UIRQ_ID_NUM];

  // one comparator per entry; constants only, nothing here can be written
  genvar gi;
  generate
    for (gi = 0; gi < `UIRQ_ID_NUM; gi++) begin : g_entry
      assign hit_vec[gi]  = (i_offset == ID_OFF[gi]);
      assign byte_vec[gi] = hit_vec[gi] ? ID_VAL[gi] : 8'h00;
    end
  endgenerate

  // offsets are distinct, so an or of the gated bytes is the selected byte
  always_comb begin
    o_byte = 8'h00;
    for (int k = 0; k < `UIRQ_ID_NUM; k++) begin
      o_byte = o_byte | byte_vec[k];
    end
  end

  assign o_hit = |hit_vec;

endmodule
`default_nettype wire

// File: rtl/uirq_regs.sv
// interrupt status, interrupt clear and identification registers of one serial port
//
// Overview of operation
// - masked bits 10..7: overrun, break, parity, framing
// - masked bit is raw bit and mask bit
// - clear write of one drops raw and masked, except for a source that sets in the same cycle
// - clear write of zero changes nothing
// - clear bits 10..4 in overrun-to-rx order
// - clear register write-one-to-clear at 0x044
// - reserved bits read zero except raw status bits 3..0, which read ones; writes ignored
// - id registers are fixed read-only constants
// - id words at offsets 0xfd0 to 0xfe4
// - layout repeated at three instance bases
`timescale 1ns/1ps
`default_nettype none
`include "uirq_consts.svh"

module uirq_regs
  import uirq_pkg::*;
#(
  // which of the three instance bases this copy answers at (0, 1 or 2)
  parameter int unsigned PORT_SEL = 0
)(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // register port
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // interrupt sources from the rest of the port
  input  wire logic [6:0]  i_event_set,
  input  wire logic [6:0]  i_irq_mask,
  // status and clear pulses toward the rest of the port
  output logic      [6:0]  o_raw_status,
  output logic      [6:0]  o_masked_status,
  output logic      [6:0]  o_clear_pulse,
  // interrupt request
  output logic             o_irq
);

  // instance base picked once at elaboration
  localparam logic [31:0] BASE_ADDR =
    (PORT_SEL == 2) ? `UIRQ_BASE_PORT2 :
    (PORT_SEL == 1) ? `UIRQ_BASE_PORT1 :
                      `UIRQ_BASE_PORT0;

  // state
  uirq_vec_type raw_reg;
  uirq_vec_type masked_reg;
  uirq_vec_type clear_pulse_reg;
  logic         irq_reg;
  logic [31:0]  rdata_reg;

  // next values and decode
  uirq_vec_type raw_next;
  uirq_vec_type masked_next;
  uirq_vec_type clear_vec;
  logic [31:0]  rdata_next;
  logic [11:0]  offset;
  logic         inst_sel;
  logic         clear_hit;
  uirq_acc_type acc_kind;
  logic [7:0]   id_byte;
  logic         id_hit;

  //--------------------------------------------------------------------
  // address decode
  //--------------------------------------------------------------------

  // upper address bits pick the instance, low twelve the register
  assign offset   = i_addr[`UIRQ_OFF_MSB:`UIRQ_OFF_LSB];
  assign inst_sel = (i_addr[`UIRQ_BASE_MSB:`UIRQ_BASE_LSB] ==
                     BASE_ADDR[`UIRQ_BASE_MSB:`UIRQ_BASE_LSB]);

  // strobes never overlap; write is checked first only for safety
  always_comb begin
    acc_kind = UIRQ_ACC_IDLE;
    if (inst_sel && i_wr) begin
      acc_kind = UIRQ_ACC_WRITE;
    end else if (inst_sel && i_rd) begin
      acc_kind = UIRQ_ACC_READ;
    end
  end

  // only the clear word has a write effect; every other write is dropped
  always_comb begin
    clear_hit = 1'b0;
    case (acc_kind)
      UIRQ_ACC_WRITE: begin
        clear_hit = (offset == `UIRQ_OFF_CLEAR);
      end
      UIRQ_ACC_READ: begin
        clear_hit = 1'b0;
      end
      default: begin
        clear_hit = 1'b0;
      end
    endcase
  end

  // field 10..4 of the write data, reserved data bits never looked at
  assign clear_vec = clear_hit ?
                     i_wdata[`UIRQ_FIELD_MSB:`UIRQ_FIELD_LSB] :
                     `UIRQ_VEC_ZERO;

  //--------------------------------------------------------------------
  // sticky raw status, one slice per source
  //--------------------------------------------------------------------

  // an event in the clearing cycle survives: set wins over clear,
  // otherwise a pulse arriving with the write would be lost for good
  genvar gi;
  generate
    for (gi = 0; gi < `UIRQ_NUM_SRC; gi++) begin : g_src
      assign raw_next[gi] = i_event_set[gi] |
                            (raw_reg[gi] & ~clear_vec[gi]);
      assign masked_next[gi] = raw_next[gi] & i_irq_mask[gi];
    end
  endgenerate

  // raw status register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      raw_reg <= `UIRQ_VEC_ZERO;
    end else begin
      raw_reg <= raw_next;
    end
  end

  // masked copy follows raw and mask together
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      masked_reg <= `UIRQ_VEC_ZERO;
    end else begin
      masked_reg <= masked_next;
    end
  end

  // one-cycle clear pulses so the rest of the port can drop its own
  // condition sources; a zero bit sends no pulse
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      clear_pulse_reg <= `UIRQ_VEC_ZERO;
    end else begin
      clear_pulse_reg <= clear_vec;
    end
  end

  // level interrupt, high while any enabled status bit is set
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |masked_next;
    end
  end

  //--------------------------------------------------------------------
  // read path
  //--------------------------------------------------------------------

  // fixed identification bytes
  uirq_id_rom u_id_rom (
    .i_offset (offset),
    .o_byte   (id_byte),
    .o_hit    (id_hit)
  );

  // read mux; unmapped and misaligned offsets read as zero
  always_comb begin
    rdata_next = `UIRQ_WORD_ZERO;
    case (offset)
      `UIRQ_OFF_RAW: begin
        rdata_next[`UIRQ_FIELD_MSB:`UIRQ_FIELD_LSB] = raw_reg;
        rdata_next[`UIRQ_RAW_LOW_MSB:`UIRQ_RAW_LOW_LSB] = `UIRQ_RAW_LOW_VAL;
      end
      `UIRQ_OFF_MASKED: begin
        // bit 10 overrun, 9 break, 8 parity, 7 framing
        // bit 6 rx timeout, 5 tx, 4 rx
        rdata_next[`UIRQ_FIELD_MSB:`UIRQ_FIELD_LSB] = masked_reg;
      end
      `UIRQ_OFF_CLEAR: begin
        rdata_next = `UIRQ_WORD_ZERO;
      end
      default: begin
        if (id_hit) begin
          rdata_next[`UIRQ_ID_BYTE_W-1:0] = id_byte;
        end
      end
    endcase
  end

  // data valid only in the cycle after the read strobe, zero otherwise
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_reg <= `UIRQ_WORD_ZERO;
    end else if (acc_kind == UIRQ_ACC_READ) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= `UIRQ_WORD_ZERO;
    end
  end

  // outputs straight from flip-flops
  assign o_rdata         = rdata_reg;
  assign o_raw_status    = raw_reg;
  assign o_masked_status = masked_reg;
  assign o_clear_pulse   = clear_pulse_reg;
  assign o_irq           = irq_reg;

endmodule
`default_nettype wire

// File: sim/uirq_regs_assertions.sv
// assertion checker for the serial port irq bank
`timescale 1ns/1ps
`default_nettype none
`include "uirq_consts.svh"
module uirq_regs_chk #(
  parameter int unsigned PORT_SEL = 0
)(
  // clock, reset and register port
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  // sources and status
  input wire logic [6:0]  i_event_set,
  input wire logic [6:0]  i_irq_mask,
  input wire logic [6:0]  o_raw_status,
  input wire logic [6:0]  o_masked_status,
  input wire logic [6:0]  o_clear_pulse,
  input wire logic        o_irq
);
  localparam logic [31:0] BASE = `UIRQ_BASE_PORT0 + 32'(PORT_SEL) * 32'h1000;
  // decoded hits, kept out of the properties for readability
  wire logic hit_msk = (i_addr == BASE + 32'h040);
  wire logic hit_clr = (i_addr == BASE + 32'h044);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  mask_gate_a: assert property ($past(i_rst_b) |->
    o_masked_status == (o_raw_status & $past(i_irq_mask))) else $error("masked mismatch");
  irq_level_a: assert property (o_irq == |o_masked_status) else $error("irq level");
  clr_pulse_a: assert property ($past(i_rst_b && i_wr && hit_clr) |->
    o_clear_pulse == $past(i_wdata[10:4])) else $error("clear pulse bits");
  clr_drop_a: assert property ((o_clear_pulse & o_raw_status & ~$past(i_event_set)) == 7'h00)
    else $error("raw survived clear");
  raw_hold_a: assert property ($past(i_rst_b) |->
    ($past(o_raw_status) & ~o_raw_status & ~o_clear_pulse) == 7'h00) else $error("raw lost");
  pulse_wr_a: assert property (!$past(i_wr && hit_clr) |-> o_clear_pulse == 7'h00)
    else $error("stray clear pulse");
  rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0) else $error("rdata idle");
  rd_mask_a: assert property ($past(i_rd && hit_msk) |->
    o_rdata == {21'h0, $past(o_masked_status), 4'h0}) else $error("masked read");
endmodule
`default_nettype wire

// File: sim/test_uirq_regs.sv
// self-checking bench for the serial port irq bank
`timescale 1ns/1ps
`default_nettype none
`include "uirq_consts.svh"
module test_uirq_regs;
  localparam logic [31:0] B = `UIRQ_BASE_PORT0;
  logic        i_clk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0, o_irq;
  logic [31:0] i_addr = 32'h0, i_wdata = 32'h0, o_rdata;
  logic [6:0]  i_event_set = 7'h00, i_irq_mask = 7'h00;
  logic [6:0]  o_raw_status, o_masked_status, o_clear_pulse;
  int          failures = 0, compares = 0, cyc = 0, k;
  uirq_regs #(.PORT_SEL(0)) dut (.i_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_event_set, .i_irq_mask, .o_raw_status, .o_masked_status,
    .o_clear_pulse, .o_irq);
  always #50 i_clk = ~i_clk;
  // ceiling well above the under 80 cycles the sequence needs
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      close_out();
    end
  end
  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  // one-cycle strobes, released at the next edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk("rdata", e, o_rdata);
  endtask
  task automatic ev(input logic [6:0] v);
    @(posedge i_clk);
    i_event_set <= v;
    @(posedge i_clk);
    i_event_set <= 7'h00;
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rd(B + 32'h03c, 32'h0000_000f);
    rd(B + 32'h044, 32'h0);
    wr(B + 32'hfe0, 32'hffff_ffff);
    for (k = 0; k < 6; k++) begin
      rd(B + 32'hfd0 + 32'(4 * k), (k == 4) ? 32'(`UIRQ_ID0_VAL) : 32'h0);
    end
    rd(B + 32'h100, 32'h0);
    rd(`UIRQ_BASE_PORT1 + 32'hfe0, 32'h0);
    // masked sources stay off the interrupt line
    ev(7'h41);
    #1 chk("irq", 32'h0, {31'h0, o_irq});
    rd(B + 32'h03c, 32'h0000_041f);
    rd(B + 32'h040, 32'h0);
    @(posedge i_clk) i_irq_mask <= 7'h40;
    rd(B + 32'h040, 32'h0000_0400);
    chk("irq", 32'h1, {31'h0, o_irq});
    wr(B + 32'h040, 32'hffff_ffff);
    wr(B + 32'h044, 32'h0000_0410);
    #1 chk("clear pulse", 32'h41, {25'h0, o_clear_pulse});
    rd(B + 32'h03c, 32'h0000_000f);
    // all pending, then drop one source per write, reserved ones written too
    @(posedge i_clk) i_irq_mask <= 7'h7f;
    ev(7'h7f);
    wr(B + 32'h044, 32'h0);
    rd(B + 32'h040, 32'h0000_07f0);
    for (k = 0; k < 7; k++) begin
      wr(B + 32'h044, (32'h10 << k) | 32'hffff_f80f);
      rd(B + 32'h040, (32'h7f0 << (k + 1)) & 32'h7f0);
    end
    chk("irq", 32'h0, {31'h0, o_irq});
    close_out();
  end
endmodule
bind uirq_regs uirq_regs_chk #(.PORT_SEL(PORT_SEL)) u_chk (.i_clk, .i_rst_b, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .i_event_set, .i_irq_mask, .o_raw_status,
  .o_masked_status, .o_clear_pulse, .o_irq);
`default_nettype wire
